// [core/tmc_consts.vh]
// constants of the 16-bit timer with compare output unit
// assumes a 32-bit apb slave with word-aligned registers
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH
// ****************************************
// register byte offsets
// ****************************************
`define TMC_OFS_CTRL   8'h00
`define TMC_OFS_FORCE  8'h04
`define TMC_OFS_COUNT  8'h08
`define TMC_OFS_CMPA   8'h0C
`define TMC_OFS_CMPB   8'h10
`define TMC_OFS_CAPT   8'h14
`define TMC_OFS_STAT   8'h18
`define TMC_OFS_PORT   8'h1C
// ****************************************
// field positions
// ****************************************
`define TMC_CTRL_WGM_LO  0
`define TMC_CTRL_WGM_HI  3
`define TMC_CTRL_COMA_LO 4
`define TMC_CTRL_COMA_HI 5
`define TMC_CTRL_COMB_LO 6
`define TMC_CTRL_COMB_HI 7
`define TMC_CTRL_RUN     8
`define TMC_FORCE_A      0
`define TMC_FORCE_B      1
`define TMC_STAT_OVF     0
`define TMC_STAT_CFA     1
`define TMC_STAT_CFB     2
`define TMC_STAT_CAP     3
`define TMC_PORT_OUTA    0
`define TMC_PORT_DIRA    1
`define TMC_PORT_OUTB    2
`define TMC_PORT_DIRB    3
`define TMC_PORT_STA     4
`define TMC_PORT_STB     5
// ****************************************
// reset values and modes
// ****************************************
`define TMC_RST_CTRL     9'h000
`define TMC_RST_WORD     16'h0000
`define TMC_RST_PORT     4'h0
`define TMC_WGM_NORMAL   4'h0
`define TMC_WGM_CTC_OCR  4'h4
`define TMC_WGM_CTC_ICR  4'hC
`define TMC_WGM_RSVD     4'hD
`define TMC_COM_OFF      2'h0
`define TMC_COM_TOGGLE   2'h1
`define TMC_COM_CLEAR    2'h2
`define TMC_COM_SET      2'h3
`endif

// [core/tmc_counter.v]
// counting core: up counter, clear on match, overflow and matches
// assumes tick is a one-cycle timer clock enable in the pclk domain
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.vh"
module tmc_counter #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire         tick,      // timer clock cycle
  input  wire [3:0]   wgm,       // wave_gen_mode
  input  wire [W-1:0] cmp_a,     // compare_reg_a
  input  wire [W-1:0] cmp_b,     // second compare value
  input  wire [W-1:0] top_icr,   // capture_reg as top
  input  wire         wr_en,     // software write of counter
  input  wire [W-1:0] wr_data,
  output reg  [W-1:0] count,     // counter_value
  output wire         match_a,   // compare match pulses
  output wire         match_b,
  output wire         ovf,       // max to zero this edge
  output wire         bottom     // counter goes to zero this edge
);
  reg  blocked;                  // matches masked for one tick
  wire ctc_a = (wgm == `TMC_WGM_CTC_OCR);
  wire ctc_i = (wgm == `TMC_WGM_CTC_ICR);
  wire eq_a  = (count == cmp_a);
  wire eq_b  = (count == cmp_b);
  wire eq_i  = (count == top_icr);
  // matches only count in a timer cycle not following a write
  assign match_a = tick & eq_a & ~blocked & ~wr_en;
  assign match_b = tick & eq_b & ~blocked & ~wr_en;
  // only modes 4 and 12 clear; the output mode never enters here
  wire top_hit = (ctc_a & match_a) | (ctc_i & tick & eq_i & ~blocked & ~wr_en);
  // wrap from max counts as overflow, a ctc clear does not
  assign ovf    = tick & (&count) & ~top_hit & ~wr_en;
  assign bottom = ovf | top_hit;
  // ****************************************
  // counter register
  // ****************************************
  // write wins over tick; block stays until the next tick passes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count   <= {W{1'b0}};
      blocked <= 1'b0;
    end else if (wr_en) begin
      count   <= wr_data;
      blocked <= 1'b1;
    end else if (tick) begin
      blocked <= 1'b0;
      if (top_hit) begin
        count <= {W{1'b0}};
      end else begin
        count <= count + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // tmc_counter
`default_nettype wire

// [core/tmc_cmp_out.v]
// compare output state of one channel
// assumes match, force and bottom are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.vh"
module tmc_cmp_out (
  input  wire       clk,
  input  wire       rstn,
  input  wire [1:0] mode,   // cmp_out_mode
  input  wire       pwm,    // counting mode is a pwm mode
  input  wire       match,  // real compare match
  input  wire       forced, // force_cmp_strobe
  input  wire       bottom, // counter restarts at zero
  output reg        state   // cmp_out_state
);
  // ****************************************
  // state update
  // ****************************************
  // mode is read live, so a new setting acts at the next match
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= 1'b0;
    end else if (pwm) begin
      // pwm polarity: clear-on-match or set-on-match, undone at bottom
      if (match && mode == `TMC_COM_CLEAR) begin
        state <= 1'b0;
      end else if (match && mode == `TMC_COM_SET) begin
        state <= 1'b1;
      end else if (bottom && mode == `TMC_COM_CLEAR) begin
        state <= 1'b1;
      end else if (bottom && mode == `TMC_COM_SET) begin
        state <= 1'b0;
      end
    end else if (match || forced) begin
      case (mode)
        `TMC_COM_TOGGLE: state <= ~state;
        `TMC_COM_CLEAR:  state <= 1'b0;
        `TMC_COM_SET:    state <= 1'b1;
        default:         state <= state;
      endcase
    end
  end
endmodule // tmc_cmp_out
`default_nettype wire

// [core/tmc_top.v]
// top of the 16-bit timer: apb registers, counter, two outputs
// assumes a synchronous apb master and inputs synchronous to pclk
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.vh"
module tmc_top #(
  parameter W = 16
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        timer_tick,      // timer clock enable
  input  wire        capture_event,   // input capture trigger
  input  wire        ovf_service_ack, // overflow interrupt serviced
  output reg         overflow_flag,
  output reg         pin_a_out,
  output reg         pin_a_oe,
  output reg         pin_b_out,
  output reg         pin_b_oe
);
  // ****************************************
  // declarations
  // ****************************************
  reg  [8:0]   ctrl;           // mode fields and run bit
  reg  [W-1:0] compare_reg_a;  // direct, no double buffer
  reg  [W-1:0] compare_reg_b;
  reg  [W-1:0] capture_reg;
  reg  [3:0]   port_ctrl;      // port outputs and directions
  reg          compare_flag_a;
  reg          compare_flag_b;
  reg          capture_flag;
  reg  [31:0]  next_prdata;    // read mux
  reg          next_slverr;    // unmapped address
  wire [W-1:0] counter_value;
  wire         match_a;
  wire         match_b;
  wire         ovf;
  wire         bottom;
  wire         cmp_out_state_a;
  wire         cmp_out_state_b;

  wire [3:0] wave_gen_mode  = ctrl[`TMC_CTRL_WGM_HI:`TMC_CTRL_WGM_LO];
  wire [1:0] cmp_out_mode_a = ctrl[`TMC_CTRL_COMA_HI:`TMC_CTRL_COMA_LO];
  wire [1:0] cmp_out_mode_b = ctrl[`TMC_CTRL_COMB_HI:`TMC_CTRL_COMB_LO];
  wire       run            = ctrl[`TMC_CTRL_RUN];
  wire       tick           = run & timer_tick;

  // ****************************************
  // helper functions
  // ****************************************
  // true for every mode that is not normal, ctc or reserved
  function is_pwm;
    input [3:0] m;
    begin
      is_pwm = (m != `TMC_WGM_NORMAL) && (m != `TMC_WGM_CTC_OCR) &&
               (m != `TMC_WGM_CTC_ICR) && (m != `TMC_WGM_RSVD);
    end
  endfunction

  // word field of a 32-bit bus value
  function [W-1:0] lo_word;
    input [31:0] d;
    begin
      lo_word = d[W-1:0];
    end
  endfunction

  // ****************************************
  // apb decode
  // ****************************************
  wire setup  = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr     = access & pwrite;
  wire wr_ctrl  = wr & (paddr == `TMC_OFS_CTRL);
  wire wr_force = wr & (paddr == `TMC_OFS_FORCE);
  wire wr_count = wr & (paddr == `TMC_OFS_COUNT);
  wire wr_cmpa  = wr & (paddr == `TMC_OFS_CMPA);
  wire wr_cmpb  = wr & (paddr == `TMC_OFS_CMPB);
  wire wr_capt  = wr & (paddr == `TMC_OFS_CAPT);
  wire wr_stat  = wr & (paddr == `TMC_OFS_STAT);
  wire wr_port  = wr & (paddr == `TMC_OFS_PORT);
  wire pwm      = is_pwm(wave_gen_mode);
  // force only acts outside pwm modes
  wire force_a = wr_force & pwdata[`TMC_FORCE_A] & ~pwm;
  wire force_b = wr_force & pwdata[`TMC_FORCE_B] & ~pwm;

  // ****************************************
  // read mux
  // ****************************************
  // reserved bits read as zero; unknown offsets answer slverr
  always @* begin
    next_prdata = 32'h00000000;
    next_slverr = 1'b0;
    case (paddr)
      `TMC_OFS_CTRL: begin
        next_prdata[8:0] = ctrl;
      end
      `TMC_OFS_FORCE: begin
        next_prdata = 32'h00000000; // strobes read zero
      end
      `TMC_OFS_COUNT: begin
        next_prdata[W-1:0] = counter_value;
      end
      `TMC_OFS_CMPA: begin
        next_prdata[W-1:0] = compare_reg_a;
      end
      `TMC_OFS_CMPB: begin
        next_prdata[W-1:0] = compare_reg_b;
      end
      `TMC_OFS_CAPT: begin
        next_prdata[W-1:0] = capture_reg;
      end
      `TMC_OFS_STAT: begin
        next_prdata[`TMC_STAT_OVF] = overflow_flag;
        next_prdata[`TMC_STAT_CFA] = compare_flag_a;
        next_prdata[`TMC_STAT_CFB] = compare_flag_b;
        next_prdata[`TMC_STAT_CAP] = capture_flag;
      end
      `TMC_OFS_PORT: begin
        next_prdata[3:0]           = port_ctrl;
        next_prdata[`TMC_PORT_STA] = cmp_out_state_a;
        next_prdata[`TMC_PORT_STB] = cmp_out_state_b;
      end
      default: begin
        next_slverr = 1'b1;
      end
    endcase
  end

  // ****************************************
  // apb answer
  // ****************************************
  // ready raised at setup, so the first access cycle completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata  <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_slverr;
      end else if (access) begin
        pslverr <= 1'b0;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  // counting follows wave_gen_mode and the run bit; cmp modes go elsewhere
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl          <= `TMC_RST_CTRL;
      compare_reg_a <= `TMC_RST_WORD;
      compare_reg_b <= `TMC_RST_WORD;
      port_ctrl     <= `TMC_RST_PORT;
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata[8:0];
      end
      if (wr_cmpa) begin
        compare_reg_a <= lo_word(pwdata);
      end
      if (wr_cmpb) begin
        compare_reg_b <= lo_word(pwdata);
      end
      if (wr_port) begin
        port_ctrl <= pwdata[3:0];
      end
    end
  end

  // ****************************************
  // input capture
  // ****************************************
  // capture ignores cmp_out_mode; no capture while it is ctc top
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_reg <= `TMC_RST_WORD;
    end else if (wr_capt) begin
      capture_reg <= lo_word(pwdata);
    end else if (capture_event && wave_gen_mode != `TMC_WGM_CTC_ICR) begin
      capture_reg <= counter_value;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // set wins over a clear in the same cycle; writes of one clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag  <= 1'b0;
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
      capture_flag   <= 1'b0;
    end else begin
      if (ovf) begin
        overflow_flag <= 1'b1;
      end else if (ovf_service_ack || (wr_stat && pwdata[`TMC_STAT_OVF])) begin
        overflow_flag <= 1'b0;
      end
      // forced compares never reach these flags
      if (match_a) begin
        compare_flag_a <= 1'b1;
      end else if (wr_stat && pwdata[`TMC_STAT_CFA]) begin
        compare_flag_a <= 1'b0;
      end
      if (match_b) begin
        compare_flag_b <= 1'b1;
      end else if (wr_stat && pwdata[`TMC_STAT_CFB]) begin
        compare_flag_b <= 1'b0;
      end
      if (capture_event && wave_gen_mode != `TMC_WGM_CTC_ICR) begin
        capture_flag <= 1'b1;
      end else if (wr_stat && pwdata[`TMC_STAT_CAP]) begin
        capture_flag <= 1'b0;
      end
    end
  end

  // ****************************************
  // counter and output units
  // ****************************************
  tmc_counter #(
    .W       (W)
  ) u_counter (
    .clk     (pclk),
    .rstn    (presetn),
    .tick    (tick),
    .wgm     (wave_gen_mode),
    .cmp_a   (compare_reg_a),
    .cmp_b   (compare_reg_b),
    .top_icr (capture_reg),
    .wr_en   (wr_count),
    .wr_data (lo_word(pwdata)),
    .count   (counter_value),
    .match_a (match_a),
    .match_b (match_b),
    .ovf     (ovf),
    .bottom  (bottom)
  );

  tmc_cmp_out u_out_a (
    .clk    (pclk),
    .rstn   (presetn),
    .mode   (cmp_out_mode_a),
    .pwm    (pwm),
    .match  (match_a),
    .forced (force_a),
    .bottom (bottom),
    .state  (cmp_out_state_a)
  );

  tmc_cmp_out u_out_b (
    .clk    (pclk),
    .rstn   (presetn),
    .mode   (cmp_out_mode_b),
    .pwm    (pwm),
    .match  (match_b),
    .forced (force_b),
    .bottom (bottom),
    .state  (cmp_out_state_b)
  );

  // ****************************************
  // pin override
  // ****************************************
  // state lives apart from the pin, so it can be set while the
  // direction is still input; one cycle later than the state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_out <= 1'b0;
      pin_a_oe  <= 1'b0;
      pin_b_out <= 1'b0;
      pin_b_oe  <= 1'b0;
    end else begin
      pin_a_out <= (cmp_out_mode_a != `TMC_COM_OFF) ? cmp_out_state_a :
                   port_ctrl[`TMC_PORT_OUTA];
      pin_b_out <= (cmp_out_mode_b != `TMC_COM_OFF) ? cmp_out_state_b :
                   port_ctrl[`TMC_PORT_OUTB];
      pin_a_oe  <= port_ctrl[`TMC_PORT_DIRA];
      pin_b_oe  <= port_ctrl[`TMC_PORT_DIRB];
    end
  end
endmodule // tmc_top
`default_nettype wire

// [test/tmc_top_checker.sv]
// checker for the timer top: apb timing, flag lifetimes, pin causes
// assumes it is bound to tmc_top and sees only the top's ports
`timescale 1ns/1ps
`default_nettype none
module tmc_top_checker #(
  parameter W = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_tick,
  input wire logic        capture_event,
  input wire logic        ovf_service_ack,
  input wire logic        overflow_flag,
  input wire logic        pin_a_out,
  input wire logic        pin_a_oe,
  input wire logic        pin_b_out,
  input wire logic        pin_b_oe
);
  // ****************************************
  // helper decode of accepted transfers
  // ****************************************
  wire acc     = psel && penable && pready;                  // transfer taken
  wire port_wr = acc && pwrite && (paddr == 8'h1C);          // port register write
  wire stat_wr = acc && pwrite && (paddr == 8'h18);          // flag clear path
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  a_ready_next: assert property (s_setup |=> s_access)
    else $error("no ready in first access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_err_unmapped: assert property ((psel && !penable && paddr > 8'h1C) |=> pslverr && pready)
    else $error("unmapped access not refused");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_count_upper_zero: assert property (acc && !pwrite && paddr == 8'h08 |-> prdata[31:16] == 16'h0)
    else $error("counter read upper half not zero");
  a_ovf_holds: assert property (
    overflow_flag && !ovf_service_ack && !stat_wr |=> overflow_flag)
    else $error("overflow flag cleared by itself");
  a_ovf_ack_clear: assert property (ovf_service_ack && !timer_tick |=> !overflow_flag)
    else $error("service ack left overflow flag set");
  a_oe_dir_a: assert property (port_wr |-> ##2 pin_a_oe == $past(pwdata[1], 2))
    else $error("pin a enable does not follow direction bit");
  a_oe_dir_b: assert property (port_wr |-> ##2 pin_b_oe == $past(pwdata[3], 2))
    else $error("pin b enable does not follow direction bit");
  a_pin_cause: assert property ($changed(pin_a_out) |-> $past(timer_tick || acc, 2))
    else $error("pin a changed without tick or register access");
endmodule // tmc_top_checker
bind tmc_top tmc_top_checker #(.W(W)) tmc_top_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_tick(timer_tick), .capture_event(capture_event), .ovf_service_ack(ovf_service_ack),
  .overflow_flag(overflow_flag), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
  .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe)
);
`default_nettype wire

// [test/tmc_pin_model.sv]
// port pads seen from the board: driven level or weak pull-down
// assumes the enables are high while the timer drives the pads
`timescale 1ns/1ps
`default_nettype none
module tmc_pin_model (
  input  wire logic out_a,
  input  wire logic oe_a,
  input  wire logic out_b,
  input  wire logic oe_b,
  output logic      level_a,
  output logic      level_b
);
  // released pad falls to the pull-down, never keeps a stale value
  assign level_a = oe_a ? out_a : 1'b0;
  assign level_b = oe_b ? out_b : 1'b0;
endmodule // tmc_pin_model
`default_nettype wire

// [test/tmc_bench.sv]
// self-checking bench for the timer top against an integer model
// assumes the checker is bound in and the pads come from the pin model
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.vh"
module timer16_compare_output_normal_ctc_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        timer_tick, capture_event, ovf_service_ack, overflow_flag;
  logic        pin_a_out, pin_a_oe, pin_b_out, pin_b_oe, level_a, level_b;
  int          num_errors = 0;
  int          n_checks = 0;
  int          m_cnt = 0, m_cmpa = 0, m_capt = 0, m_wgm = 0, m_coma = 0; // model
  logic        m_sta = 1'b0, m_ovf = 1'b0, m_cfa = 1'b0, m_blk = 1'b0;
  int          fmode[5] = '{3, 1, 1, 0, 2};                             // force table
  int          clear_on_match_mode[2] = '{4, 12};
  tmc_top #(.W(16)) tmc_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_tick(timer_tick), .capture_event(capture_event), .ovf_service_ack(ovf_service_ack),
    .overflow_flag(overflow_flag), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
  tmc_pin_model tmc_pin_model_inst (.out_a(pin_a_out), .oe_a(pin_a_oe), .out_b(pin_b_out),
    .oe_b(pin_b_oe), .level_a(level_a), .level_b(level_b));
  // ****************************************
  // clock and shared tasks
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  // apb master: request held until ready is seen, released after that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_ctrl(input int wgm, input int coma, input int run);
    m_wgm  = wgm;
    m_coma = coma;
    apb(1'b1, `TMC_OFS_CTRL, 32'(run * 256 + coma * 16 + wgm));
  endtask
  // a counter write blocks matches at the next tick
  task automatic set_count(input int v);
    m_cnt = v;
    m_blk = 1'b1;
    apb(1'b1, `TMC_OFS_COUNT, 32'(v));
  endtask
  function automatic logic act(input logic s, input int mode);
    case (mode)
      1: return ~s;
      2: return 1'b0;
      3: return 1'b1;
      default: return s;
    endcase
  endfunction
  // one timer clock cycle, model follows the count before the tick
  task automatic tick();
    logic hit, top;
    @(posedge pclk);
    timer_tick <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    hit = !m_blk && (m_cnt == m_cmpa);
    top = !m_blk && ((m_wgm == 4 && hit) || (m_wgm == 12 && m_cnt == m_capt));
    m_blk = 1'b0;
    if (hit) begin
      m_sta = act(m_sta, m_coma);
      m_cfa = 1'b1;
    end
    if (top) begin
      m_cnt = 0;
    end else begin
      m_cnt = (m_cnt + 1) % 65536;
      if (m_cnt == 0) m_ovf = 1'b1;
    end
  endtask
  task automatic check_all();
    apb(1'b0, `TMC_OFS_COUNT, 32'h0);
    chk_word(rd, 32'(m_cnt));
    apb(1'b0, `TMC_OFS_STAT, 32'h0);
    chk_word(rd & 32'h3, {30'h0, m_cfa, m_ovf});
    apb(1'b0, `TMC_OFS_PORT, 32'h0);
    chk_bit(rd[`TMC_PORT_STA], m_sta);
    chk_bit(overflow_flag, m_ovf);
  endtask
  // watchdog far beyond the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {presetn, psel, penable, pwrite, timer_tick, capture_event, ovf_service_ack} = 7'h00;
    paddr  = 8'h00;
    pwdata = 32'h0;
    void'($urandom(32'h5385564F));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `TMC_OFS_PORT, 32'h0);
    chk_word(rd, 32'h0);
    chk_bit(pin_a_oe, 1'b0);
    apb(1'b1, 8'h20, 32'hFFFFFFFF);
    chk_bit(err, 1'b1);
    apb(1'b0, 8'h20, 32'h0);
    chk_word(rd, 32'h0);
    // forced actions while the pad is still released
    foreach (fmode[i]) begin
      set_ctrl(0, fmode[i], 0);
      apb(1'b1, `TMC_OFS_FORCE, 32'h1);
      m_sta = act(m_sta, fmode[i]);
      check_all();
      chk_bit(level_a, 1'b0);
    end
    // force is ignored in a pwm mode, state must stay put
    set_ctrl(5, 3, 0);
    apb(1'b1, `TMC_OFS_FORCE, 32'h1);
    check_all();
    set_ctrl(0, 3, 0);
    apb(1'b1, `TMC_OFS_FORCE, 32'h1);
    m_sta = 1'b1;
    apb(1'b1, `TMC_OFS_PORT, 32'h2);
    set_ctrl(0, 2, 0);
    apb(1'b0, `TMC_OFS_PORT, 32'h0);
    chk_bit(level_a, 1'b1);
    chk_bit(rd[`TMC_PORT_STA], 1'b1);
    set_ctrl(0, 0, 0);
    apb(1'b0, `TMC_OFS_PORT, 32'h0);
    chk_bit(level_a, 1'b0);
    // channel b: set by force, then shown once its pad drives
    apb(1'b1, `TMC_OFS_CTRL, 32'h000000C0);
    apb(1'b1, `TMC_OFS_FORCE, 32'h2);
    apb(1'b1, `TMC_OFS_PORT, 32'h8);
    apb(1'b0, `TMC_OFS_PORT, 32'h0);
    chk_bit(rd[`TMC_PORT_STB], 1'b1);
    chk_bit(level_b, 1'b1);
    // wrap through zero with compare at zero, no clear in normal mode
    set_count(16'hFFFD);
    set_ctrl(0, 1, 1);
    repeat (5) tick();
    check_all();
    @(posedge pclk) ovf_service_ack <= 1'b1;
    @(posedge pclk) ovf_service_ack <= 1'b0;
    m_ovf = 1'b0;
    check_all();
    // counter rewritten while running, compare near it
    repeat (3) begin
      m_cmpa = $urandom % 65536;
      apb(1'b1, `TMC_OFS_CMPA, 32'(m_cmpa));
      set_count((m_cmpa + 65536 - $urandom % 4) % 65536);
      repeat (6) tick();
      check_all();
    end
    foreach (clear_on_match_mode[i]) begin
      m_capt = 1 + $urandom % 4;
      m_cmpa = 1 + $urandom % 4;
      apb(1'b1, `TMC_OFS_CAPT, 32'(m_capt));
      apb(1'b1, `TMC_OFS_CMPA, 32'(m_cmpa));
      apb(1'b1, `TMC_OFS_STAT, 32'hF);
      {m_cfa, m_ovf} = 2'b00;
      set_count(0);
      set_ctrl(clear_on_match_mode[i], 1, 1);
      repeat (11) tick();
      check_all();
    end
    set_ctrl(0, 3, 0);
    @(posedge pclk) capture_event <= 1'b1;
    @(posedge pclk) capture_event <= 1'b0;
    apb(1'b0, `TMC_OFS_CAPT, 32'h0);
    chk_word(rd, 32'(m_cnt));
    check_all();
    report_and_stop();
  end
endmodule // timer16_compare_output_normal_ctc_bench
`default_nettype wire
